// ==== scut_channel.sv ====
// Purpose: One serial channel: clocking, slot gating, UART framing.
// Assumes: All inputs synchronous to core_clk (10 MHz).
// Notes: Registers reached over a plain strobe port.
//
// Notes on behaviour
// - No serial clocks outside slot; slot rise starts clocking, one sync pulse.
// - Slot mode with no data ready sends all-ones bytes.
// - One bit per slot clock; state held unclocked between slots.
// - Receive clock and data pass only during the active slot.
// - After request-to-send, next slot rise sends all-ones then buffer bytes.
// - Chained buffers without last flag go back to back; one lead byte.
// - Request-to-send follows enable plus ready data after some serial clocks in slot mode, at once on byte take otherwise.
// - Baud source: main clock when 0, timer pin when 1.
// - Transmit clock: baud generator when 0, transmit clock pin when 1.
// - Receive clock: baud generator when 0, transmit clock pin when 1.
// - Divider field presets an 11-bit down-counter at prescaler rate.
// - Prescaler divides by 1 when 0, by 4 when 1.
// - Transmit parity: 00 odd, 01 zero, 10 even, 11 one.
// - Parity enable adds and checks parity; receive mode odd 0, even 1.
// - Last stop bit length 9/16 to 16/16 by code; reset gives 16/16.
// - Writing one clears an event bit; zero leaves it.
// - Event register sits on the upper byte lane.
// - Clear-to-send and carrier changes set their event bits.
// - Line quiet change and break reception set their event bits.
// - Rejected control character is stored and sets its event bit.
// - Character dropped for lack of buffer sets the no-buffer event.
`default_nettype none

module scut_channel #(
  parameter int RTS_DELAY = 8,
  parameter int IDLE_BITS = 10
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic timer_input_one_pin,
  input wire logic tx_clock_pin,
  input wire logic [1:0] slot_sync_pins,
  input wire logic cts_n,
  input wire logic cd_n,
  input wire logic rxd,
  output logic txd,
  output logic rts_n,
  output logic slot_sync_pulse,
  input wire scut_pkg::scut_tx_s tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  output scut_pkg::scut_rx_s rx_char,
  output logic rx_valid,
  input wire logic rx_buf_free,
  input wire logic ctrl_match_reject
);

  // ****************************************************
  // Declarations
  // ****************************************************
  logic [15:0] channel_clock_config, channel_mode, stop_bit_fraction;
  logic [7:0] uart_events, rx_control_char_reg;
  logic tin_q, tx_clock_pin_q, cts_q, cd_q, slot_q;
  logic [1:0] pre_cnt;
  logic [10:0] brg_cnt;
  scut_pkg::scut_state_e st;
  logic [7:0] sh;
  logic [3:0] sub, bitn;
  logic par, last_q, rts;
  logic [5:0] rts_cnt;
  logic rx_busy, rx_par, quiet_q;
  logic [3:0] rx_sub, rx_bitn;
  logic [7:0] rx_sh, quiet_cnt;

  // Parity of a byte by mode code
  function automatic logic par_of(input logic [1:0] m,
                                  input logic [7:0] d);
    unique case (m)
      2'h0: par_of = ~^d;
      2'h1: par_of = 1'b0;
      2'h2: par_of = ^d;
      default: par_of = 1'b1;
    endcase
  endfunction

  // ****************************************************
  // Register decode
  // ****************************************************
  wire sel_cfg = addr == scut_pkg::OFF_CLK_CFG;
  wire sel_mode = addr == scut_pkg::OFF_MODE;
  wire sel_stop = addr == scut_pkg::OFF_STOP;
  wire sel_ev = addr == scut_pkg::OFF_EVENTS;
  wire sel_cc = addr == scut_pkg::OFF_CTRL_CHAR;
  wire [7:0] ev_clr = (wr && sel_ev) ?
    wdata[scut_pkg::EV_LANE_LO+:8] : 8'h00;
  wire [15:0] rd_mux =
    sel_cfg ? channel_clock_config :
    sel_mode ? channel_mode :
    sel_stop ? stop_bit_fraction :
    sel_ev ? {uart_events, 8'h00} :
    sel_cc ? {8'h00, rx_control_char_reg} : 16'h0000;

  // Control fields
  wire ext = channel_clock_config[scut_pkg::CFG_EXT];
  wire tx_clock_select = channel_clock_config[scut_pkg::CFG_TCS];
  wire rx_clock_select = channel_clock_config[scut_pkg::CFG_RCS];
  wire quarter = channel_clock_config[scut_pkg::CFG_QUARTER];
  wire [10:0] divider = channel_clock_config[scut_pkg::CFG_DIV_LO+:11];
  wire [1:0] tpm = channel_mode[scut_pkg::MODE_TPM_LO+:2];
  wire rx_parity_mode = channel_mode[scut_pkg::MODE_RPM];
  wire parity_on = channel_mode[scut_pkg::MODE_PEN];
  wire rx_enable_bit = channel_mode[scut_pkg::MODE_ENR];
  wire tx_enable_bit = channel_mode[scut_pkg::MODE_ENT];
  wire tdm_on = channel_mode[1:0] == scut_pkg::MODE_TDM;
  wire [2:0] stop_code = stop_bit_fraction[scut_pkg::STOP_LO+:3];

  // ****************************************************
  // Clock sources and slot gating
  // ****************************************************
  wire slot_act = |slot_sync_pins;
  wire slot_rise = slot_act && !slot_q;
  wire src_tick = ext ? (timer_input_one_pin && !tin_q) : 1'b1;
  wire pre_tick = src_tick && (!quarter || pre_cnt == 2'h3);
  wire brg_tick = pre_tick && brg_cnt == 11'h000;
  wire tx_clock_pin_edge = tx_clock_pin && !tx_clock_pin_q;
  wire tx_clk = tx_clock_select ? tx_clock_pin_edge : brg_tick;
  wire rx_clk = rx_clock_select ? tx_clock_pin_edge : brg_tick;
  wire gate = !tdm_on || slot_act;
  wire tx_tick = tx_clk && gate;
  wire rx_tick = rx_clk && gate;
  wire rx_in = gate ? rxd : 1'b1;

  // Pin history and baud generator
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tin_q <= 1'b0;
      tx_clock_pin_q <= 1'b0;
      cts_q <= 1'b1;
      cd_q <= 1'b1;
      slot_q <= 1'b0;
      pre_cnt <= 2'h0;
      brg_cnt <= 11'h000;
      slot_sync_pulse <= 1'b0;
    end else begin
      tin_q <= timer_input_one_pin;
      tx_clock_pin_q <= tx_clock_pin;
      cts_q <= cts_n;
      cd_q <= cd_n;
      slot_q <= slot_act;
      slot_sync_pulse <= slot_rise;
      if (src_tick)
        pre_cnt <= pre_cnt + 2'h1;
      if (pre_tick)
        brg_cnt <= brg_tick ? divider : brg_cnt - 11'h001;
    end
  end

  // ****************************************************
  // Transmitter
  // ****************************************************
  wire in_idle = st == scut_pkg::S_IDLE;
  wire byte_end = st == scut_pkg::S_TDM && tx_tick && bitn == 4'h7;
  wire bit_end = tx_tick && sub == scut_pkg::OSR_LAST;
  wire stop_end = tx_tick && sub == {1'b1, stop_code};
  assign tx_ready = tx_enable_bit && ((in_idle && !tdm_on) ||
                    (byte_end && !last_q));
  wire tx_take = tx_ready && tx_valid;
  wire tx_done = last_q && ((byte_end && !tx_enable_bit) || byte_end ||
                 (st == scut_pkg::S_STOP && stop_end));
  assign rts_n = !rts;

  // Line level per state
  always_comb begin
    unique case (st)
      scut_pkg::S_TDM: txd = sh[0];
      scut_pkg::S_START: txd = 1'b0;
      scut_pkg::S_DATA: txd = sh[0];
      scut_pkg::S_PAR: txd = par;
      default: txd = 1'b1;
    endcase
  end

  // Transmit sequencing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= scut_pkg::S_IDLE;
      sh <= 8'hFF;
      sub <= 4'h0;
      bitn <= 4'h0;
      par <= 1'b0;
      last_q <= 1'b0;
      rts <= 1'b0;
      rts_cnt <= 6'h00;
    end else begin
      unique case (st)
        scut_pkg::S_IDLE: begin
          rts_cnt <= 6'h00;
          sub <= 4'h0;
          if (tx_enable_bit && tdm_on && tx_valid)
            st <= scut_pkg::S_RTS;
          else if (tx_take) begin
            sh <= tx_byte.data;
            last_q <= tx_byte.last;
            par <= par_of(tpm, tx_byte.data);
            rts <= 1'b1;
            st <= scut_pkg::S_START;
          end
        end
        scut_pkg::S_RTS: begin
          if (!tx_enable_bit || !tdm_on)
            st <= scut_pkg::S_IDLE;
          else if (tx_clk) begin
            rts_cnt <= rts_cnt + 6'h01;
            if (rts_cnt == 6'(RTS_DELAY - 1)) begin
              rts <= 1'b1;
              st <= scut_pkg::S_SYNC;
            end
          end
        end
        scut_pkg::S_SYNC: begin
          if (!tx_enable_bit) begin
            rts <= 1'b0;
            st <= scut_pkg::S_IDLE;
          end else if (slot_rise) begin
            sh <= scut_pkg::LEAD_BYTE;
            bitn <= 4'h0;
            last_q <= 1'b0;
            st <= scut_pkg::S_TDM;
          end
        end
        scut_pkg::S_TDM: begin
          if (byte_end) begin
            bitn <= 4'h0;
            if (last_q || !tx_enable_bit) begin
              rts <= 1'b0;
              st <= scut_pkg::S_IDLE;
            end else if (tx_take) begin
              sh <= tx_byte.data;
              last_q <= tx_byte.last;
            end else
              sh <= scut_pkg::LEAD_BYTE;
          end else if (tx_tick) begin
            sh <= {1'b1, sh[7:1]};
            bitn <= bitn + 4'h1;
          end
        end
        scut_pkg::S_START, scut_pkg::S_DATA, scut_pkg::S_PAR: begin
          if (tx_tick)
            sub <= sub + 4'h1;
          if (bit_end && st == scut_pkg::S_START) begin
            bitn <= 4'h0;
            st <= scut_pkg::S_DATA;
          end else if (bit_end && st == scut_pkg::S_DATA) begin
            sh <= {1'b1, sh[7:1]};
            bitn <= bitn + 4'h1;
            if (bitn == 4'h7)
              st <= parity_on ? scut_pkg::S_PAR : scut_pkg::S_STOP;
          end else if (bit_end)
            st <= scut_pkg::S_STOP;
        end
        scut_pkg::S_STOP: begin
          sub <= sub + {3'h0, tx_tick};
          if (stop_end) begin
            sub <= 4'h0;
            rts <= 1'b0;
            st <= scut_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************
  // Receiver
  // ****************************************************
  wire [3:0] rx_last_bit = parity_on ? 4'hA : 4'h9;
  wire rx_sample = rx_busy && rx_tick && rx_sub == scut_pkg::MID_BIT;
  wire rx_end = rx_sample && rx_bitn == rx_last_bit;
  wire rx_brk = rx_end && !rx_in && rx_sh == 8'h00 &&
                !(parity_on && rx_par);
  wire rx_good = rx_end && !rx_brk;
  wire perr = parity_on && rx_par != par_of({rx_parity_mode, 1'b0}, rx_sh);
  wire quiet = quiet_cnt == 8'(IDLE_BITS * 16);

  // Character assembly, delivery and quiet detection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_busy <= 1'b0;
      rx_sub <= 4'h0;
      rx_bitn <= 4'h0;
      rx_sh <= 8'h00;
      rx_par <= 1'b0;
      rx_valid <= 1'b0;
      rx_char <= '0;
      quiet_cnt <= 8'h00;
      quiet_q <= 1'b0;
    end else begin
      rx_valid <= rx_good && rx_buf_free;
      quiet_q <= quiet;
      if (!rx_in)
        quiet_cnt <= 8'h00;
      else if (rx_tick && !quiet)
        quiet_cnt <= quiet_cnt + 8'h01;
      if (rx_good)
        rx_char <= '{data: rx_sh, parity_err: perr};
      if (!rx_enable_bit)
        rx_busy <= 1'b0;
      else if (!rx_busy && rx_tick && !rx_in) begin
        rx_busy <= 1'b1;
        rx_sub <= 4'h0;
        rx_bitn <= 4'h0;
      end else if (rx_busy && rx_tick) begin
        rx_sub <= rx_sub + 4'h1;
        if (rx_sample) begin
          rx_bitn <= rx_bitn + 4'h1;
          if (rx_bitn == 4'h0 && rx_in)
            rx_busy <= 1'b0;
          else if (rx_bitn >= 4'h1 && rx_bitn <= 4'h8)
            rx_sh <= {rx_in, rx_sh[7:1]};
          else if (rx_bitn == 4'h9 && parity_on)
            rx_par <= rx_in;
          if (rx_end)
            rx_busy <= 1'b0;
        end
      end
    end
  end

  // ****************************************************
  // Registers and events
  // ****************************************************
  wire ccr_hit = rx_valid && ctrl_match_reject;
  wire [7:0] ev_set = {cts_n != cts_q, cd_n != cd_q,
                       quiet != quiet_q, rx_brk,
                       ccr_hit, rx_good && !rx_buf_free,
                       tx_done, rx_valid};

  // Software writes, sticky events, read port
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      channel_clock_config <= scut_pkg::CFG_RST;
      channel_mode <= scut_pkg::MODE_RST;
      stop_bit_fraction <= scut_pkg::STOP_RST;
      uart_events <= 8'h00;
      rx_control_char_reg <= 8'h00;
      rdata <= 16'h0000;
    end else begin
      if (wr && sel_cfg)
        channel_clock_config <= wdata;
      if (wr && sel_mode)
        channel_mode <= wdata;
      if (wr && sel_stop)
        stop_bit_fraction <= wdata;
      if (ccr_hit)
        rx_control_char_reg <= rx_char.data;
      uart_events <= (uart_events & ~ev_clr) | ev_set;
      rdata <= rd ? rd_mux : 16'h0000;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  a_slot_hold: assert property (@(posedge core_clk) disable iff (rst)
    st == scut_pkg::S_TDM && !slot_act |=> $stable(sh))
    else $error("shift state moved outside slot");
  a_lead_byte: assert property (@(posedge core_clk) disable iff (rst)
    st == scut_pkg::S_SYNC && tx_enable_bit && slot_rise
    |=> sh == 8'hFF && st == scut_pkg::S_TDM)
    else $error("no lead byte at slot start");
  a_sync_pulse: assert property (@(posedge core_clk) disable iff (rst)
    slot_rise |=> slot_sync_pulse ##1 !slot_sync_pulse)
    else $error("sync pulse not one cycle");
  a_rx_gated: assert property (@(posedge core_clk) disable iff (rst)
    tdm_on && !slot_act |-> !rx_tick && rx_in)
    else $error("receive clocked outside slot");
  a_idle_fill: assert property (@(posedge core_clk) disable iff (rst)
    byte_end && tx_enable_bit && !last_q && !tx_valid
    |=> sh == 8'hFF)
    else $error("idle fill not all ones");
  a_ev_clear: assert property (@(posedge core_clk) disable iff (rst)
    wr && sel_ev && wdata[15] && cts_n == cts_q
    |=> !uart_events[scut_pkg::EV_CTS])
    else $error("event bit not cleared");
  a_ev_sticky: assert property (@(posedge core_clk) disable iff (rst)
    ##1 (uart_events & $past(uart_events & ~ev_clr))
    == $past(uart_events & ~ev_clr))
    else $error("event bit lost without clear");
  a_cts_event: assert property (@(posedge core_clk) disable iff (rst)
    cts_n != cts_q |=> uart_events[scut_pkg::EV_CTS])
    else $error("clear-to-send change not latched");
  a_cd_event: assert property (@(posedge core_clk) disable iff (rst)
    cd_n != cd_q |=> uart_events[scut_pkg::EV_CD])
    else $error("carrier change not latched");
  a_force_par: assert property (@(posedge core_clk) disable iff (rst)
    $rose(st == scut_pkg::S_PAR) && $past(tpm, 2) == 2'h3
    && tpm == 2'h3 |-> txd)
    else $error("forced high parity wrong");

endmodule

`default_nettype wire

// ==== scut_pkg.sv ====
// Purpose: Shared constants and types of the serial channel block.
// Assumes: 12-bit register address, 16-bit register data.
// Notes: Event register sits on data bits 15 to 8.
`default_nettype none

package scut_pkg;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [11:0] OFF_CLK_CFG = 12'h882;
  localparam logic [11:0] OFF_MODE = 12'h884;
  localparam logic [11:0] OFF_STOP = 12'h886;
  localparam logic [11:0] OFF_EVENTS = 12'h888;
  localparam logic [11:0] OFF_CTRL_CHAR = 12'h88A;

  // ****************************************************
  // Field positions and codes
  // ****************************************************
  localparam int CFG_EXT = 14;
  localparam int CFG_TCS = 13;
  localparam int CFG_RCS = 12;
  localparam int CFG_DIV_LO = 1;
  localparam int CFG_QUARTER = 0;
  localparam int MODE_TPM_LO = 14;
  localparam int MODE_RPM = 13;
  localparam int MODE_PEN = 12;
  localparam int MODE_ENR = 3;
  localparam int MODE_ENT = 2;
  localparam logic [1:0] MODE_TDM = 2'h3;
  localparam int STOP_LO = 12;
  localparam int EV_LANE_LO = 8;
  localparam int EV_CTS = 7;
  localparam int EV_CD = 6;

  // ****************************************************
  // Reset values and counts
  // ****************************************************
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] STOP_RST = 16'h7000;
  localparam logic [3:0] OSR_LAST = 4'hF;
  localparam logic [3:0] MID_BIT = 4'h7;
  localparam logic [7:0] LEAD_BYTE = 8'hFF;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_RTS = 8'h02,
    S_SYNC = 8'h04,
    S_TDM = 8'h08,
    S_START = 8'h10,
    S_DATA = 8'h20,
    S_PAR = 8'h40,
    S_STOP = 8'h80
  } scut_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } scut_tx_s;

  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
  } scut_rx_s;

endpackage

`default_nettype wire

// ==== scut_peer.sv ====
// Purpose: Remote UART at the far end of the serial line.
// Assumes: One bit lasts 16 core_clk cycles in both directions.
// Notes: Idle line is high; frames are handed over whole, start bit first.
`default_nettype none

module scut_peer (
  input wire logic core_clk,
  input wire logic txd,
  input wire logic send,
  input wire logic [10:0] frame,
  output var logic rxd,
  output logic [7:0] got_byte,
  output logic got_extra
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [10:0] shreg = 11'h7FF;
  logic [9:0] rsh = 10'h000;
  int scnt = 0;
  int rcnt = 0;

  // ****************************************************
  // Sender and receiver
  // ****************************************************
  // Frame bits leave LSB first, 16 cycles each; idle line stays high
  always_comb rxd = (scnt > 0) ? shreg[(176 - scnt) / 16] : 1'b1;

  // Load a frame or count down through it
  always @(posedge core_clk) begin
    if (send) begin
      shreg <= frame;
      scnt <= 176;
    end else if (scnt > 0) begin
      scnt <= scnt - 1;
    end
  end

  // Sample txd mid-bit: start, eight data bits LSB first, one more bit
  always @(posedge core_clk) begin
    if (rcnt == 0 && txd == 1'b0) begin
      rcnt <= 1;
    end else if (rcnt >= 160 && txd == 1'b1) begin
      rcnt <= 0;
    end else if (rcnt > 0) begin
      rcnt <= rcnt + 1;
    end
    if (rcnt % 16 == 8 && rcnt < 160) begin
      rsh <= {txd, rsh[9:1]};
    end
    if (rcnt == 153) begin
      got_byte <= rsh[8:1];
      got_extra <= rsh[9];
    end
  end

endmodule

`default_nettype wire

// ==== serial_channel_uart_tdm_test.sv ====
// Purpose: Self-checking bench of the serial channel block.
// Assumes: 10 MHz core clock; baud tick every cycle unless set.
// Notes: External clock pins run at a quarter of the core clock.
`default_nettype none

module serial_channel_uart_tdm_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic timer_input_one_pin = 1'b0;
  logic tx_clock_pin = 1'b0;
  logic [1:0] slot_sync_pins = 2'h0;
  logic cts_n = 1'b1;
  logic cd_n = 1'b1;
  logic rxd;
  logic txd;
  logic rts_n;
  logic slot_sync_pulse;
  scut_pkg::scut_tx_s tx_byte = '0;
  logic tx_valid = 1'b0;
  logic tx_ready;
  scut_pkg::scut_rx_s rx_char;
  logic rx_valid;
  logic rx_buf_free = 1'b1;
  logic ctrl_match_reject = 1'b0;
  logic send = 1'b0;
  logic [10:0] frame = 11'h7FF;
  logic [7:0] got_byte;
  logic got_extra;
  logic [1:0] ext_div = 2'h0;
  int fail_count = 0;
  int comparisons = 0;

  // Block under test and the remote UART
  scut_channel #(.RTS_DELAY(1), .IDLE_BITS(1)) u_scut_channel (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata),
    .timer_input_one_pin(timer_input_one_pin),
    .tx_clock_pin(tx_clock_pin), .slot_sync_pins(slot_sync_pins),
    .cts_n(cts_n), .cd_n(cd_n), .rxd(rxd), .txd(txd), .rts_n(rts_n),
    .slot_sync_pulse(slot_sync_pulse), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_char(rx_char),
    .rx_valid(rx_valid), .rx_buf_free(rx_buf_free),
    .ctrl_match_reject(ctrl_match_reject));
  scut_peer u_scut_peer (
    .core_clk(core_clk), .txd(txd), .send(send), .frame(frame),
    .rxd(rxd), .got_byte(got_byte), .got_extra(got_extra));

  // Core clock and external clock pins
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    ext_div <= ext_div + 2'h1;
    tx_clock_pin <= ext_div[1];
    timer_input_one_pin <= ext_div[1];
  end

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic test_done();
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_up(input string what);
    check(what, 16'h0001, 16'h0000);
    test_done();
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp, mask,
                        input string what);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    check(what, rdata & mask, exp);
  endtask

  // Hand one byte over, time the frame, count low cycles after a high bit
  task automatic send_tx(input logic [7:0] b, output int busy, low);
    int i;
    logic hi;
    busy = 0;
    low = 0;
    hi = 1'b0;
    @(posedge core_clk);
    tx_byte <= {b, 1'b1};
    tx_valid <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(negedge core_clk);
      if (tx_ready === 1'b1) break;
    end
    if (i == 100) give_up("tx take");
    @(posedge core_clk);
    tx_valid <= 1'b0;
    do begin
      @(negedge core_clk);
      busy++;
      if (txd === 1'b1) hi = 1'b1;
      else if (txd === 1'b0 && hi) low++;
    end while (tx_ready !== 1'b1 && busy < 5000);
    if (busy == 5000) give_up("tx end");
  endtask

  // Remote sends one frame; note whether a character came out
  task automatic rx_in(input logic [10:0] f, input logic free, rej,
                       output logic got);
    got = 1'b0;
    @(posedge core_clk);
    frame <= f;
    send <= 1'b1;
    rx_buf_free <= free;
    ctrl_match_reject <= rej;
    @(posedge core_clk);
    send <= 1'b0;
    for (int i = 0; i < 250 && !got; i++) begin
      @(negedge core_clk);
      got = (rx_valid === 1'b1);
    end
    repeat (30) @(posedge core_clk);
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_regs();
    rd_chk(scut_pkg::OFF_CLK_CFG, 16'h0000, 16'hFFFF, "cfg");
    rd_chk(scut_pkg::OFF_MODE, 16'h0000, 16'hFFFF, "mode");
    rd_chk(scut_pkg::OFF_STOP, 16'h7000, 16'hFFFF, "stop");
    rd_chk(scut_pkg::OFF_EVENTS, 16'h0000, 16'hDFFF, "events");
    reg_wr(12'h88C, 16'hFFFF);
    rd_chk(12'h88C, 16'h0000, 16'hFFFF, "unmapped");
    reg_wr(scut_pkg::OFF_STOP, 16'h3000);
    rd_chk(scut_pkg::OFF_STOP, 16'h3000, 16'h7000, "stop rw");
  endtask

  task automatic t_events();
    repeat (40) @(posedge core_clk);
    rd_chk(scut_pkg::OFF_EVENTS, 16'h2000, 16'h2000, "quiet");
    reg_wr(scut_pkg::OFF_EVENTS, 16'hFF00);
    rd_chk(scut_pkg::OFF_EVENTS, 16'h0000, 16'hFFFF, "cleared");
    @(posedge core_clk);
    cts_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd_chk(scut_pkg::OFF_EVENTS, 16'h8000, 16'hFFFF, "cts");
    @(posedge core_clk);
    cd_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd_chk(scut_pkg::OFF_EVENTS, 16'hC000, 16'hFFFF, "cd");
    reg_wr(scut_pkg::OFF_EVENTS, 16'h4000);
    rd_chk(scut_pkg::OFF_EVENTS, 16'h8000, 16'hFFFF, "w1c");
    reg_wr(scut_pkg::OFF_EVENTS, 16'h8000);
    rd_chk(scut_pkg::OFF_EVENTS, 16'h0000, 16'hFFFF, "w1c");
  endtask

  task automatic t_tx();
    int busy;
    int low;
    logic [7:0] b;
    logic p;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        b = 8'h34 + 8'(k);
        p = (m == 1) ? 1'b0 : (m == 3) ? 1'b1 : (m == 0) ? ~^b : ^b;
        reg_wr(scut_pkg::OFF_MODE, 16'h1004 | (16'(m) << 14));
        send_tx(b, busy, low);
        check("tx data", {8'h00, got_byte}, {8'h00, b});
        check("tx par", {15'h0000, got_extra}, {15'h0000, p});
      end
    end
    reg_wr(scut_pkg::OFF_MODE, 16'h0004);
    send_tx(8'h34, busy, low);
    check("no par", {15'h0000, got_extra}, 16'h0001);
  endtask

  // Tick-aligned bit length under each clock source, then stop fraction
  task automatic t_timing();
    logic [15:0] cfg [5] = '{16'h0000, 16'h0001, 16'h2000, 16'h4000,
                             16'h0002};
    int len [5] = '{16, 64, 64, 64, 32};
    int n7;
    int n0;
    int low;
    for (int i = 0; i < 5; i++) begin
      reg_wr(scut_pkg::OFF_CLK_CFG, cfg[i]);
      send_tx(8'hFD, n7, low);
      check("bit", 16'(low), 16'(len[i]));
    end
    reg_wr(scut_pkg::OFF_CLK_CFG, 16'h0000);
    reg_wr(scut_pkg::OFF_STOP, 16'h7000);
    send_tx(8'hFF, n7, low);
    reg_wr(scut_pkg::OFF_STOP, 16'h0000);
    send_tx(8'hFF, n0, low);
    check("stop diff", 16'(n7 - n0), 16'h0007);
  endtask

  task automatic t_rx();
    logic got;
    reg_wr(scut_pkg::OFF_MODE, 16'h3008);
    rx_in({2'b10, 8'h5A, 1'b0}, 1'b1, 1'b0, got);
    check("rx got", {15'h0000, got}, 16'h0001);
    check("rx char", 16'(rx_char), {7'h00, 8'h5A, 1'b0});
    rx_in({2'b11, 8'h5A, 1'b0}, 1'b1, 1'b0, got);
    check("rx even", 16'(rx_char), {7'h00, 8'h5A, 1'b1});
    reg_wr(scut_pkg::OFF_MODE, 16'h1008);
    rx_in({2'b11, 8'h5A, 1'b0}, 1'b1, 1'b0, got);
    check("rx odd", 16'(rx_char), {7'h00, 8'h5A, 1'b0});
    reg_wr(scut_pkg::OFF_EVENTS, 16'hFF00);
    rx_in({2'b11, 8'h5A, 1'b0}, 1'b0, 1'b0, got);
    check("dropped", {15'h0000, got}, 16'h0000);
    rd_chk(scut_pkg::OFF_EVENTS, 16'h0400, 16'h0400, "nobuf");
    rx_in({2'b11, 8'hC3, 1'b0}, 1'b1, 1'b1, got);
    rd_chk(scut_pkg::OFF_EVENTS, 16'h0800, 16'h0800, "ctrl");
    rd_chk(scut_pkg::OFF_CTRL_CHAR, 16'h00C3, 16'h00FF, "ctrl c");
    rx_in(11'h000, 1'b1, 1'b0, got);
    rd_chk(scut_pkg::OFF_EVENTS, 16'h1000, 16'h1000, "break");
    reg_wr(scut_pkg::OFF_CLK_CFG, 16'h1000);
    rx_in({2'b11, 8'hFF, 1'b0}, 1'b1, 1'b0, got);
    check("rx tx_clock_pin", {15'h0000, got}, 16'h0000);
    reg_wr(scut_pkg::OFF_CLK_CFG, 16'h0000);
  endtask

  // Slot mode: 8-cycle slots every 20 cycles, fill byte, two chained bytes
  task automatic t_slot();
    logic [63:0] bits = '0;
    int n = 0;
    int rises = 0;
    int pulses = 0;
    int moves = 0;
    logic seen = 1'b0;
    logic rts_seen = 1'b0;
    logic prev = 1'b1;
    logic found = 1'b0;
    reg_wr(scut_pkg::OFF_MODE, 16'h0007);
    @(posedge core_clk);
    tx_byte <= {8'hA5, 1'b0};
    tx_valid <= 1'b1;
    for (int c = 0; c < 600; c++) begin
      @(posedge core_clk);
      slot_sync_pins <= (c % 20 >= 8) ? 2'h0 : (c % 40 < 20) ? 2'h1 : 2'h2;
      if (seen && tx_byte.last) tx_valid <= 1'b0;
      if (c == 2 || c == 50) tx_valid <= (c == 50);
      if (seen) tx_byte <= {8'h3C, 1'b1};
      @(negedge core_clk);
      seen = tx_valid && tx_ready === 1'b1;
      if (rts_n === 1'b0) rts_seen = 1'b1;
      if (slot_sync_pulse === 1'b1) pulses++;
      if (c % 20 == 0) rises++;
      if (slot_sync_pins != 2'h0 && rts_seen && n < 64) begin
        bits[n] = txd;
        n++;
      end
      if (c % 20 > 9 && txd !== prev) moves++;
      prev = txd;
    end
    for (int j = 0; j <= 40; j++)
      if (bits[j +: 24] == 24'h3C_A5FF) found = 1'b1;
    check("rts", {15'h0000, rts_seen}, 16'h0001);
    check("pulses", 16'(pulses), 16'(rises));
    check("gap", 16'(moves), 16'h0000);
    check("stream", {15'h0000, found}, 16'h0001);
    reg_wr(scut_pkg::OFF_MODE, 16'h000B);
    rx_in({2'b11, 8'h5A, 1'b0}, 1'b1, 1'b0, seen);
    check("rx gated", {15'h0000, seen}, 16'h0000);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_events();
    t_tx();
    t_timing();
    t_rx();
    t_slot();
    test_done();
  end

endmodule

`default_nettype wire
